// File: hw/dsp_pkg.sv
// Constants and carriers for the DRAM self-refresh / power-down state logic.
// Assumes a single 20 MHz device clock and an active-high async reset.
package dsp_pkg;

  // Clock rate and derived timing
  localparam int CLK_MHZ        = 20;
  localparam int TCKE_NS        = 5000;   // Clock-enable minimum pulse
  localparam int TCKE_CYC       = (TCKE_NS * CLK_MHZ + 999) / 1000;
  localparam int TCPDED_CYC     = 1;      // CKE-to-receiver gating delay
  localparam int TXS_CYC        = 4;      // Self-refresh exit delay
  localparam int TXSDLL_CYC     = 512;    // DLL exit delay, also write hold
  localparam int TXP_CYC        = 3;      // Power-down exit latency
  localparam int TXPDLL_CYC     = 10;     // Power-down DLL exit latency
  localparam int TREFI_NS       = 7800;   // Average refresh interval
  localparam int TREFI_CYC      = (TREFI_NS * CLK_MHZ) / 1000;
  localparam int PD_LIMIT_MULT  = 9;      // Refresh intervals per power-down
  localparam int CNT_W          = 12;

  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;

  // Mode bit positions within the mode snapshot
  localparam int MR_DLL_OFF_BIT = 0;      // Mode bit A0: 1 disables the DLL
  localparam int MR_PPD_FAST    = 12;     // Mode bit A12: fast precharge PD

  // Command bus sampled at each rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dsp_cmd_t;

  // Status bundle presented to the rest of the device
  typedef struct packed {
    logic self_refresh;
    logic power_down;
    logic active_pd;
    logic fast_exit;
    logic dll_on;
    logic dll_reset;
    logic clk_gated;
    logic rcv_gated;
    logic exit_busy;
    logic dll_busy;
    logic pd_overrun;
  } dsp_stat_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SR   = 4'b0010,
    ST_PD   = 4'b0100,
    ST_EXIT = 4'b1000
  } dsp_state_t;

endpackage

// File: hw/dsp_timer.sv
// Down-counter used for the exit delays and the self-refresh timer.
// Assumes load and the count value come from logic on the same clock.
`timescale 1ns/1ps
module dsp_timer (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   load,
  input  wire logic [dsp_pkg::CNT_W-1:0] value,
  output logic                        done,
  output logic [dsp_pkg::CNT_W-1:0]   count
);

  // Reload wins over counting so a fresh interval is never shortened
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= dsp_pkg::CNT_ZERO;
    end else if (load) begin
      count <= value;
    end else if (count != dsp_pkg::CNT_ZERO) begin
      count <= count - dsp_pkg::CNT_ONE;
    end
  end

  assign done = (count == dsp_pkg::CNT_ZERO);

endmodule

// File: hw/dsp_core.sv
// Self-refresh and power-down state logic of a DDR3 device.
// Assumes CKE, command pins and reset_n arrive as pins; they pass two flops.
// The controller is trusted to keep its own timing obligations.
// Overview of operation
// - Decode self-refresh entry command from sampled pins
// - DLL off on entry, on with reset on exit
// - Ignore inputs except CKE, reset; gate clock
// - Internal refresh within CKE pulse, then periodic
// - Enter power-down on CKE low with NOP
// - Precharge or active power-down by open banks
// - Gate buffers, receivers after CKE-to-PD delay
// - Precharge PD with A12 zero: DLL off, slow
// - Active PD or A12 one: DLL on, fast
// - Reset pin low leaves power-down to reset
`timescale 1ns/1ps
module dsp_core (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cke,
  input  wire logic              reset_n,
  input  wire dsp_pkg::dsp_cmd_t cmd,
  input  wire logic              banks_open,
  input  wire logic [15:0]       mode_bits,
  output dsp_pkg::dsp_stat_t     stat,
  output logic                   refresh_req,
  output logic                   write_block
);

  // Two-flop synchronisers for pin inputs
  logic [1:0]        cke_s;
  logic [1:0]        rstn_s;
  dsp_pkg::dsp_cmd_t cmd_s0;
  dsp_pkg::dsp_cmd_t cmd_s;
  logic              cke_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cke_s    <= 2'h0;
      rstn_s   <= 2'h0;
      cmd_s0   <= '1;
      cmd_s    <= '1;
      cke_prev <= 1'b0;
    end else begin
      cke_s    <= {cke_s[0], cke};
      rstn_s   <= {rstn_s[0], reset_n};
      cmd_s0   <= cmd;
      cmd_s    <= cmd_s0;
      cke_prev <= cke_s[1];
    end
  end

  // Command decode; shared by entry and refresh checks
  function automatic logic is_nop(input dsp_pkg::dsp_cmd_t c);
    is_nop = c.cs_n || (c.ras_n && c.cas_n && c.we_n);
  endfunction
  function automatic logic is_ref(input dsp_pkg::dsp_cmd_t c);
    is_ref = !c.cs_n && !c.ras_n && !c.cas_n && c.we_n;
  endfunction

  logic cke_now;
  logic cke_fall;
  logic cke_rise;
  logic sre_hit;
  logic pde_hit;
  logic ref_hit;
  logic pin_reset;
  assign cke_now   = cke_s[1];
  assign cke_fall  = cke_prev && !cke_now;
  assign cke_rise  = !cke_prev && cke_now;
  assign pin_reset = !rstn_s[1];
  // CKE low with refresh pattern is self-refresh entry
  assign sre_hit   = cke_fall && is_ref(cmd_s);
  assign pde_hit   = cke_fall && is_nop(cmd_s);
  assign ref_hit   = cke_now && cke_prev && is_ref(cmd_s);

  dsp_pkg::dsp_state_t state;
  dsp_pkg::dsp_state_t next_state;
  logic                exit_from_sr;
  logic                need_extra_ref;
  // Timers: exit delay, DLL delay, self-refresh refresh interval
  logic                      t_ex_load;
  logic                      t_ex_done;
  logic [dsp_pkg::CNT_W-1:0] t_ex_val;
  logic                      t_dl_load;
  logic                      t_dl_done;
  logic [dsp_pkg::CNT_W-1:0] t_dl_val;
  logic                      t_rf_load;
  logic                      t_rf_done;
  logic [dsp_pkg::CNT_W-1:0] t_rf_val;
  dsp_timer u_exit (
    .clk   (clk),
    .rst   (rst),
    .load  (t_ex_load),
    .value (t_ex_val),
    .done  (t_ex_done),
    .count ()
  );
  dsp_timer u_dll (
    .clk   (clk),
    .rst   (rst),
    .load  (t_dl_load),
    .value (t_dl_val),
    .done  (t_dl_done),
    .count ()
  );
  dsp_timer u_ref (
    .clk   (clk),
    .rst   (rst),
    .load  (t_rf_load),
    .value (t_rf_val),
    .done  (t_rf_done),
    .count ()
  );
  // Next state; pin reset dominates everything
  always_comb begin
    next_state = state;
    unique case (state)
      dsp_pkg::ST_IDLE: begin
        if (sre_hit && !need_extra_ref) begin
          next_state = dsp_pkg::ST_SR;
        end else if (pde_hit) begin
          next_state = dsp_pkg::ST_PD;
        end
      end
      // Only CKE and the reset pin are watched while asleep; command pins are ignored
      dsp_pkg::ST_SR, dsp_pkg::ST_PD: begin
        if (cke_rise) begin
          next_state = dsp_pkg::ST_EXIT;
        end
      end
      dsp_pkg::ST_EXIT: begin
        if (t_ex_done && t_dl_done) begin
          next_state = dsp_pkg::ST_IDLE;
        end else if (sre_hit && t_ex_done && !need_extra_ref) begin
          next_state = dsp_pkg::ST_SR;
        end
      end
      default: next_state = dsp_pkg::ST_IDLE;
    endcase
    if (pin_reset) begin
      next_state = dsp_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dsp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  logic enter_sr;
  logic enter_pd;
  logic leave_sleep;
  logic slow_pd;

  assign enter_sr    = (state != dsp_pkg::ST_SR)
                       && (next_state == dsp_pkg::ST_SR);
  assign enter_pd    = (state == dsp_pkg::ST_IDLE)
                       && (next_state == dsp_pkg::ST_PD);
  assign leave_sleep = (next_state == dsp_pkg::ST_EXIT)
                       && (state != dsp_pkg::ST_EXIT);
  // Slow exit only for precharge power-down with A12 clear
  assign slow_pd     = !banks_open
                       && !mode_bits[dsp_pkg::MR_PPD_FAST];

  // Timer loads: exit delays chosen by what is being left
  always_comb begin
    t_ex_load = leave_sleep;
    t_ex_val  = stat.self_refresh ? dsp_pkg::CNT_W'(dsp_pkg::TXS_CYC)
                                  : dsp_pkg::CNT_W'(dsp_pkg::TXP_CYC);
    t_dl_load = leave_sleep;
    if (stat.self_refresh) begin
      t_dl_val = dsp_pkg::CNT_W'(dsp_pkg::TXSDLL_CYC);
    end else if (!stat.fast_exit) begin
      t_dl_val = dsp_pkg::CNT_W'(dsp_pkg::TXPDLL_CYC);
    end else begin
      t_dl_val = dsp_pkg::CNT_W'(dsp_pkg::TXP_CYC);
    end
    // First refresh within the CKE pulse, then every refresh interval
    t_rf_load = enter_sr || enter_pd
                || ((state == dsp_pkg::ST_SR) && t_rf_done);
    t_rf_val  = (enter_sr || enter_pd)
                ? dsp_pkg::CNT_W'(dsp_pkg::TCKE_CYC)
                : dsp_pkg::CNT_W'(dsp_pkg::TREFI_CYC);
  end

  // Internal refresh pulse while in self-refresh, no external clock needed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refresh_req <= 1'b0;
    end else begin
      refresh_req <= (state == dsp_pkg::ST_SR) && t_rf_done;
    end
  end

  // Raised CKE may cut an internal refresh; owe one until REF, even over PD
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      need_extra_ref <= 1'b0;
      exit_from_sr   <= 1'b0;
    end else if (pin_reset) begin
      need_extra_ref <= 1'b0;
      exit_from_sr   <= 1'b0;
    end else if (leave_sleep) begin
      need_extra_ref <= need_extra_ref || stat.self_refresh;
      exit_from_sr   <= stat.self_refresh;
    end else if (ref_hit) begin
      need_extra_ref <= 1'b0;
    end
  end

  // Power-down length, counted in refresh intervals
  logic [3:0]                pd_intervals;
  logic [dsp_pkg::CNT_W-1:0] pd_cyc;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_cyc       <= dsp_pkg::CNT_ZERO;
      pd_intervals <= 4'h0;
    end else if (state != dsp_pkg::ST_PD) begin
      pd_cyc       <= dsp_pkg::CNT_ZERO;
      pd_intervals <= 4'h0;
    end else if (pd_cyc == dsp_pkg::CNT_W'(dsp_pkg::TREFI_CYC - 1)) begin
      pd_cyc       <= dsp_pkg::CNT_ZERO;
      if (pd_intervals != 4'(dsp_pkg::PD_LIMIT_MULT)) begin
        pd_intervals <= pd_intervals + 4'h1;
      end
    end else begin
      pd_cyc <= pd_cyc + dsp_pkg::CNT_ONE;
    end
  end

  // Receiver gating delay after power-down entry
  logic [1:0] cpded_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpded_cnt <= 2'h0;
    end else if (enter_pd) begin
      cpded_cnt <= 2'(dsp_pkg::TCPDED_CYC);
    end else if (cpded_cnt != 2'h0) begin
      cpded_cnt <= cpded_cnt - 2'h1;
    end
  end

  // Status flags; all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat        <= '0;
      stat.dll_on <= 1'b1;
      write_block <= 1'b0;
    end else begin
      stat.self_refresh <= (next_state == dsp_pkg::ST_SR);
      stat.power_down   <= (next_state == dsp_pkg::ST_PD);
      stat.clk_gated    <= (next_state == dsp_pkg::ST_SR);
      if (enter_pd) begin
        stat.active_pd <= banks_open;
        stat.fast_exit <= !slow_pd;
      end
      // DLL off for self-refresh with DLL enabled, or slow precharge PD
      if (enter_sr && !mode_bits[dsp_pkg::MR_DLL_OFF_BIT]) begin
        stat.dll_on <= 1'b0;
      end else if (enter_pd && slow_pd) begin
        stat.dll_on <= 1'b0;
      end else if (leave_sleep || pin_reset) begin
        stat.dll_on <= !mode_bits[dsp_pkg::MR_DLL_OFF_BIT];
      end
      stat.dll_reset <= leave_sleep && stat.self_refresh
                        && !mode_bits[dsp_pkg::MR_DLL_OFF_BIT];
      stat.rcv_gated <= (state == dsp_pkg::ST_PD)
                        && (cpded_cnt == 2'h0)
                        && (next_state == dsp_pkg::ST_PD);
      stat.exit_busy <= (next_state == dsp_pkg::ST_EXIT) && !t_ex_done;
      stat.dll_busy  <= (next_state == dsp_pkg::ST_EXIT) && !t_dl_done;
      stat.pd_overrun <= (state == dsp_pkg::ST_PD)
                         && (pd_intervals == 4'(dsp_pkg::PD_LIMIT_MULT));
      // Writes held back through the DLL delay after self-refresh exit
      write_block <= (next_state == dsp_pkg::ST_EXIT)
                     && (exit_from_sr || leave_sleep && stat.self_refresh)
                     && !t_dl_done;
    end
  end

endmodule

// File: tb/dsp_core_checker.sv
// Port assertions for the self-refresh / power-down core.
// Assumes a bind to dsp_core; one clock, async active-high reset.
`timescale 1ns/1ps
module dsp_core_checker (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cke,
  input wire logic              reset_n,
  input wire dsp_pkg::dsp_cmd_t cmd,
  input wire logic              banks_open,
  input wire logic [15:0]       mode_bits,
  input wire dsp_pkg::dsp_stat_t stat,
  input wire logic              refresh_req,
  input wire logic              write_block
);
  logic [9:0] wb_cnt;

  // Length of the write hold; restarts whenever it drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wb_cnt <= 10'h000;
    else if (write_block) wb_cnt <= wb_cnt + 10'h001;
    else wb_cnt <= 10'h000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_sr_dll_off:
    assert property ($rose(stat.self_refresh) |-> !stat.dll_on)
    else $error("dll on in self refresh");
  a_sr_clk_gate:
    assert property (stat.self_refresh |-> stat.clk_gated)
    else $error("clock running in self refresh");
  a_sr_first_ref:
    assert property ($rose(stat.self_refresh) |-> ##[1:110] refresh_req)
    else $error("no refresh after entry");
  a_exit_dll_rst:
    assert property ($fell(stat.self_refresh) |-> ##[0:2] stat.dll_reset)
    else $error("no dll reset on exit");
  a_exit_wr_hold:
    assert property ($fell(stat.self_refresh) |-> ##[0:2] write_block)
    else $error("write hold missing");
  a_wr_hold_len:
    assert property ($fell(write_block) |-> wb_cnt >= 10'h200)
    else $error("write hold too short");
  a_entry_cke_low:
    assert property ($rose(stat.self_refresh || stat.power_down) |-> !cke)
    else $error("entry without cke low");
  a_apd_fast_exit:
    assert property ($rose(stat.power_down) && banks_open |->
      stat.active_pd && stat.fast_exit && stat.dll_on)
    else $error("active power-down mode wrong");
  a_ppd_slow_exit:
    assert property ($rose(stat.power_down) && !banks_open && !mode_bits[12]
      |-> !stat.fast_exit && !stat.dll_on)
    else $error("slow precharge power-down wrong");
  a_pd_rcv_gate:
    assert property ($rose(stat.power_down) |-> ##[0:2] stat.rcv_gated)
    else $error("receivers not gated");
  a_pin_reset_pd:
    assert property ($fell(reset_n) && stat.power_down |->
      ##[1:5] !stat.power_down)
    else $error("power-down kept after pin reset");
  a_exit_busy_len:
    assert property ($rose(stat.exit_busy) |-> stat.exit_busy[*3])
    else $error("exit delay too short");

  // Main scenarios reached
  c_sr: cover property ($rose(stat.self_refresh));
  c_apd: cover property ($rose(stat.active_pd));
  c_wr_end: cover property ($fell(write_block));
endmodule

// File: tb/dsp_ctl_model.sv
// Memory controller model driving CKE, command pins and the reset pin.
// Assumes the core samples the pins on the rising edge of clk.
`timescale 1ns/1ps
module dsp_ctl_model (
  input  wire logic          clk,
  output dsp_pkg::dsp_cmd_t  cmd,
  output logic               cke,
  output logic               reset_n
);
  localparam logic [3:0] NOP = 4'h7;

  // Idle bus with CKE high
  initial begin
    cmd = dsp_pkg::dsp_cmd_t'(NOP);
    cke = 1'b1;
    reset_n = 1'b1;
  end

  // One pin update just after an edge
  task automatic drive(input logic [3:0] c, input logic k);
    @(posedge clk);
    cmd <= dsp_pkg::dsp_cmd_t'(c);
    cke <= k;
  endtask

  // Refresh with CKE high; required before self-refresh re-entry
  task automatic refresh();
    drive(4'h1, 1'b1);
    drive(NOP, 1'b1);
  endtask

  // CKE low phase; ignored pins carry changing noise, not a stale value
  task automatic cke_low(input logic [3:0] entry, input int n);
    drive(entry, 1'b0);
    drive(NOP, 1'b0);
    for (int i = 0; i < n; i++) drive(4'(i), 1'b0);
    drive(NOP, 1'b1);
    repeat (dsp_pkg::TXPDLL_CYC) drive(NOP, 1'b1);
  endtask

  // Short low pulse on the reset pin
  task automatic pin_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
  endtask
endmodule

// File: tb/dram_self_refresh_power_down_tb.sv
// Self-checking bench for the self-refresh / power-down core.
// Assumes the controller model drives the pins; 20 MHz clock.
`timescale 1ns/1ps
module dram_self_refresh_power_down_tb;
  logic               clk;
  logic               rst;
  logic               banks_open;
  logic [15:0]        mode_bits;
  logic               cke;
  logic               reset_n;
  logic               refresh_req;
  logic               write_block;
  dsp_pkg::dsp_cmd_t  cmd;
  dsp_pkg::dsp_stat_t stat;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int refs = 0;
  int rsts = 0;

  dsp_core u_dsp_core (.clk(clk), .rst(rst), .cke(cke), .reset_n(reset_n),
    .cmd(cmd), .banks_open(banks_open), .mode_bits(mode_bits), .stat(stat),
    .refresh_req(refresh_req), .write_block(write_block));
  dsp_ctl_model u_dsp_ctl_model (.clk(clk), .cmd(cmd), .cke(cke),
    .reset_n(reset_n));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulse counters and a watchdog well beyond the planned run
  always @(posedge clk) begin
    cyc++;
    if (refresh_req === 1'b1) refs++;
    if (stat.dll_reset === 1'b1) rsts++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Sample after the edge's updates have landed
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_mode(input logic b, input logic [15:0] m);
    @(posedge clk);
    banks_open <= b;
    mode_bits <= m;
  endtask

  // Entry, timer refresh, exit with DLL reset and write hold
  task automatic t_self_refresh();
    int r0;
    int d0;
    d0 = rsts;
    fork
      u_dsp_ctl_model.cke_low(4'h1, 300);
      begin
        idle(8);
        check("in sr", stat.self_refresh, 1);
        check("clk gated", stat.clk_gated, 1);
        check("dll on", stat.dll_on, 0);
        r0 = refs;
        idle(dsp_pkg::TCKE_CYC);
        check("sr refresh", 16'(refs - r0 >= 1), 1);
      end
    join
    #1;
    check("dll reset", 16'(rsts - d0), 1);
    check("dll busy", stat.dll_busy, 1);
    check("wr hold", write_block, 1);
    idle(480);
    check("wr hold late", write_block, 1);
    idle(40);
    check("wr free", write_block, 0);
  endtask

  // Re-entry refused until an extra refresh is seen
  task automatic t_reentry();
    fork
      u_dsp_ctl_model.cke_low(4'h1, 110);
      begin
        idle(10);
        check("re-entry no ref", stat.self_refresh, 0);
      end
    join
    idle(dsp_pkg::TXSDLL_CYC + 20);
    u_dsp_ctl_model.refresh();
    fork
      u_dsp_ctl_model.cke_low(4'h1, 110);
      begin
        idle(10);
        check("re-entry ref", stat.self_refresh, 1);
      end
    join
    idle(dsp_pkg::TXSDLL_CYC + 20);
  endtask

  // Power-down variant chosen by open banks and mode bit A12
  task automatic t_pd(input logic b, input logic a12, input logic [2:0] e);
    set_mode(b, {3'h0, a12, 12'h000});
    fork
      u_dsp_ctl_model.cke_low(4'h7, 110);
      begin
        idle(8);
        check("in pd", stat.power_down, 1);
        check("rcv gated", stat.rcv_gated, 1);
        check("pd kind", {stat.active_pd, stat.fast_exit, stat.dll_on},
          e);
      end
    join
    idle(120);
  endtask

  // Overlong power-down raises the overrun status after nine intervals
  task automatic t_pd_limit();
    fork
      u_dsp_ctl_model.cke_low(4'h7, 1420);
      begin
        idle(1395);
        check("pd no overrun", stat.pd_overrun, 0);
        idle(20);
        check("pd overrun", stat.pd_overrun, 1);
      end
    join
    idle(120);
  endtask

  // Reset pin low in power-down leaves it
  task automatic t_pin_reset();
    fork
      u_dsp_ctl_model.cke_low(4'h7, 110);
      begin
        idle(30);
        u_dsp_ctl_model.pin_reset();
        idle(8);
        check("pd after pin reset", stat.power_down, 0);
      end
    join
    idle(120);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    banks_open = 1'b0;
    mode_bits = 16'h0000;
    idle(3);
    check("reset stat", stat, 16'h0040);
    @(posedge clk);
    rst <= 1'b0;
    idle(5);
    t_self_refresh();
    t_reentry();
    t_pd(1'b0, 1'b0, 3'h0);
    t_pd(1'b0, 1'b1, 3'h3);
    t_pd(1'b1, 1'b0, 3'h7);
    t_pd_limit();
    t_pin_reset();
    final_report();
  end
endmodule

bind dsp_core dsp_core_checker u_dsp_core_checker (.clk(clk), .rst(rst),
  .cke(cke), .reset_n(reset_n), .cmd(cmd), .banks_open(banks_open),
  .mode_bits(mode_bits), .stat(stat), .refresh_req(refresh_req),
  .write_block(write_block));
